/* File: rtl/irq_prio_defines.svh */
// Register indices, field positions and reset values of the interrupt block.
// Assumes the includer works in word indices, byte address being four times each.
`ifndef IRQ_PRIO_DEFINES_SVH
`define IRQ_PRIO_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------------
`define IDX_G0_REQ    12'hfc0
`define IDX_G0_HI     12'hfc1
`define IDX_G0_LO     12'hfc2
`define IDX_PA_REQ    12'hfc3
`define IDX_PA_HI     12'hfc4
`define IDX_PA_LO     12'hfc5
`define IDX_PC_REQ    12'hfc6
`define IDX_SHARED    12'hfce
`define IDX_CTRL      12'hfcf
`define IDX_EVT_STAT  12'hfd0
`define IDX_EVT_CLR   12'hfd1
`define IDX_EVT_EN    12'hfd2

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define G0_IMPL_MASK  8'h79
`define PC_IMPL_MASK  8'h0f
`define SHARED_MASK   8'hc0
`define SHARED_VOLT   7
`define SHARED_CMP    6
`define MASTER_EN     7
`define REG_RESET     8'h00
`define EVT_LOST      0
`define EVT_ACK       1
`define EVT_WIDTH     2
`define NUM_SRC       20
`define NUM_PINS      12
`define PA_BASE       8
`define PC_BASE       16

`endif

/* File: rtl/irq_prio_pkg.sv */
// Types shared by the interrupt priority block and its arbiter.
// Assumes nothing beyond a SystemVerilog compiler.
package irq_prio_pkg;

  // Two-bit priority decode of a high/low enable pair
  typedef enum logic [1:0] {
    LVL_OFF  = 2'h0,
    LVL_LOW  = 2'h1,
    LVL_MED  = 2'h2,
    LVL_HIGH = 2'h3
  } prio_level_t;

  typedef logic [4:0] src_idx_t;

endpackage

/* File: rtl/irq_arb_if.sv */
// Carrier between the request block and its priority arbiter.
// Assumes the arbiter is purely combinational.
`timescale 1ns/100ps
interface irq_arb_if #(parameter int N = 20);
  logic [N-1:0]            pend;
  logic [2*N-1:0]          levels;
  logic                    found;
  irq_prio_pkg::src_idx_t    winner;
  irq_prio_pkg::prio_level_t level;

  modport requester (output pend, levels, input found, winner, level);
  modport arbiter   (input pend, levels, output found, winner, level);
endinterface

/* File: rtl/irq_prio_select.sv */
// Picks the highest-level enabled pending source; lowest index wins a tie.
// Assumes levels[2i+1:2i] is the decoded level of source i.
`timescale 1ns/100ps
module irq_prio_select #(
  parameter int N = 20
) (
  irq_arb_if.arbiter arb
);
  import irq_prio_pkg::*;

  if (N < 1 || N > 32) begin : g_bad_n
    $error("irq_prio_select: N must be 1 to 32");
  end

  always_comb begin
    logic [1:0] lvl;
    lvl = 2'h0;
    arb.found  = 1'b0;
    arb.winner = '0;
    arb.level  = LVL_OFF;
    // Strict compare keeps the earlier source on an equal level
    for (int i = 0; i < N; i++) begin
      lvl = arb.levels[2*i +: 2];
      if (arb.pend[i] && lvl != 2'h0 && (!arb.found || lvl > arb.level)) begin
        arb.found  = 1'b1;
        arb.winner = src_idx_t'(i);
        arb.level  = prio_level_t'(lvl);
      end
    end
  end

endmodule // irq_prio_select

/* File: rtl/irq_request_priority_enable.sv */
// Interrupt request latches for three groups and two-bit priority enables for group 0 and port A,
// with an Avalon-MM register slave and a vectored request to the core.
// Assumes same-clock source pulses and asynchronous port pins.
`timescale 1ns/100ps
`include "irq_prio_defines.svh"

module irq_request_priority_enable (
  // Clock and reset
  input  wire logic                      clock,
  input  wire logic                      reset_n,
  // Avalon-MM slave, word index addressing
  input  wire logic [11:0]               address,
  input  wire logic                      read,
  input  wire logic                      write,
  input  wire logic [31:0]               writedata,
  output logic      [31:0]               readdata,
  output logic                           waitrequest,
  // Same-clock request pulses and shared-source levels
  input  wire logic                      timer1Event,
  input  wire logic                      timer0Event,
  input  wire logic                      serialRxEvent,
  input  wire logic                      serialTxEvent,
  input  wire logic                      converterEvent,
  input  wire logic                      lowVoltageLevel,
  input  wire logic                      comparatorLevel,
  // Asynchronous port pins
  input  wire logic [7:0]                portAPin,
  input  wire logic [3:0]                portCPin,
  // Vectored request to the core
  output logic                           coreIrqReq,
  output irq_prio_pkg::src_idx_t         coreIrqVector,
  output irq_prio_pkg::prio_level_t      coreIrqLevel,
  input  wire logic                      coreIrqAck,
  // System interrupt
  output logic                           irq
);
  import irq_prio_pkg::*;

  localparam int N = `NUM_SRC;

  logic                  respondR;
  logic                  wrStb;
  logic [7:0]            rdByte;
  logic [7:0]            wByte;
  logic [7:0]            g0HiR, g0LoR, paHiR, paLoR, sharedR;
  logic                  masterEnR;
  logic [N-1:0]          pendR, pendNxt, hwSet, ackMask;
  logic [`NUM_PINS-1:0]  sync1R, sync2R, sync3R, pinLvlR;
  logic [`NUM_PINS-1:0]  srcLvl, srcPrevR;
  logic [7:0]            paRise, g0Set;
  logic [3:0]            pcRise;
  logic [`EVT_WIDTH-1:0] evtStatR, evtEnR, evtSet;
  logic                  ackNow;

  irq_arb_if #(.N(N)) arb ();

  irq_prio_select #(.N(N)) u_select (
    .arb (arb)
  );

  // --------------------------------------------------------------------------
  // Register bus
  // --------------------------------------------------------------------------
  // One wait state on every access, so read data always come from a flop
  assign waitrequest = (read | write) & ~respondR;
  assign wrStb       = write & respondR;
  assign wByte       = writedata[7:0];

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      respondR <= 1'b0;
    end else begin
      respondR <= (read | write) & ~respondR;
    end
  end

  always_comb begin
    unique case (address)
      `IDX_G0_REQ:   rdByte = pendR[7:0];
      `IDX_G0_HI:    rdByte = g0HiR;
      `IDX_G0_LO:    rdByte = g0LoR & `G0_IMPL_MASK;
      `IDX_PA_REQ:   rdByte = pendR[`PA_BASE +: 8];
      `IDX_PA_HI:    rdByte = paHiR;
      `IDX_PA_LO:    rdByte = paLoR;
      `IDX_PC_REQ:   rdByte = {4'h0, pendR[`PC_BASE +: 4]};
      `IDX_SHARED:   rdByte = sharedR;
      `IDX_CTRL:     rdByte = {masterEnR, 7'h00};
      `IDX_EVT_STAT: rdByte = {6'h00, evtStatR};
      `IDX_EVT_EN:   rdByte = {6'h00, evtEnR};
      default:       rdByte = 8'h00;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      readdata <= 32'h0;
    end else if (read && !respondR) begin
      readdata <= {24'h0, rdByte};
    end
  end

  // --------------------------------------------------------------------------
  // Enable, select and control registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      g0HiR     <= `REG_RESET;
      g0LoR     <= `REG_RESET;
      paHiR     <= `REG_RESET;
      paLoR     <= `REG_RESET;
      sharedR   <= `REG_RESET;
      masterEnR <= 1'b0;
      evtEnR    <= '0;
    end else if (wrStb) begin
      unique case (address)
        `IDX_G0_HI:  g0HiR     <= wByte;
        `IDX_G0_LO:  g0LoR     <= wByte & `G0_IMPL_MASK;
        `IDX_PA_HI:  paHiR     <= wByte;
        `IDX_PA_LO:  paLoR     <= wByte;
        `IDX_SHARED: sharedR   <= wByte & `SHARED_MASK;
        `IDX_CTRL:   masterEnR <= wByte[`MASTER_EN];
        `IDX_EVT_EN: evtEnR    <= wByte[`EVT_WIDTH-1:0];
        default:     ;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  for (genvar i = 0; i < `NUM_PINS; i++) begin : g_sync
    logic pinIn;
    assign pinIn = (i < 8) ? portAPin[i % 8] : portCPin[i % 4];
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        sync1R[i]  <= 1'b0;
        sync2R[i]  <= 1'b0;
        sync3R[i]  <= 1'b0;
        pinLvlR[i] <= 1'b0;
      end else begin
        sync1R[i] <= pinIn;
        sync2R[i] <= sync1R[i];
        sync3R[i] <= sync2R[i];
        // A change counts only once the last two stages agree
        if (sync2R[i] == sync3R[i]) begin
          pinLvlR[i] <= sync3R[i];
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Request sources
  // --------------------------------------------------------------------------
  // Switching the shared select can itself look like an edge; software must
  // disable the source first
  assign srcLvl[7] = sharedR[`SHARED_VOLT] ? lowVoltageLevel : pinLvlR[7];
  assign srcLvl[6] = sharedR[`SHARED_CMP] ? comparatorLevel : pinLvlR[6];
  assign srcLvl[5:0]  = pinLvlR[5:0];
  assign srcLvl[11:8] = pinLvlR[11:8];

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      srcPrevR <= '0;
    end else begin
      srcPrevR <= srcLvl;
    end
  end

  assign paRise = srcLvl[7:0] & ~srcPrevR[7:0];
  assign pcRise = srcLvl[11:8] & ~srcPrevR[11:8];
  assign g0Set  = {1'b0, timer1Event, timer0Event, serialRxEvent,
                   serialTxEvent, 2'b00, converterEvent};
  assign hwSet  = {pcRise, paRise, g0Set};

  // --------------------------------------------------------------------------
  // Pending flags
  // --------------------------------------------------------------------------
  assign ackNow  = coreIrqAck & coreIrqReq;
  assign ackMask = ackNow ? (N'(1) << coreIrqVector) : '0;

  always_comb begin
    pendNxt = pendR;
    if (wrStb) begin
      unique case (address)
        `IDX_G0_REQ: pendNxt[7:0] = wByte & `G0_IMPL_MASK;
        `IDX_PA_REQ: pendNxt[`PA_BASE +: 8] = wByte;
        `IDX_PC_REQ: pendNxt[`PC_BASE +: 4] = wByte[3:0];
        default:     ;
      endcase
    end
    pendNxt = pendNxt & ~ackMask;
    // A request in the clearing cycle still lands
    pendNxt = pendNxt | hwSet;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pendR <= '0;
    end else begin
      pendR <= pendNxt;
    end
  end

  // --------------------------------------------------------------------------
  // Priority decode and forwarding
  // --------------------------------------------------------------------------
  for (genvar i = 0; i < 8; i++) begin : g_levels
    assign arb.levels[2*i +: 2]              = {g0HiR[i], g0LoR[i]};
    assign arb.levels[2*(i+`PA_BASE) +: 2]   = {paHiR[i], paLoR[i]};
  end
  // Port C has no enable pair here, so it is poll only
  assign arb.levels[2*N-1:2*`PC_BASE] = '0;
  // The acknowledged source drops out at once, avoiding a repeat vector
  assign arb.pend = pendR & ~ackMask;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      coreIrqReq    <= 1'b0;
      coreIrqVector <= '0;
      coreIrqLevel  <= LVL_OFF;
    end else begin
      coreIrqReq    <= masterEnR & arb.found;
      coreIrqVector <= arb.winner;
      coreIrqLevel  <= arb.level;
    end
  end

  // --------------------------------------------------------------------------
  // Event status and interrupt
  // --------------------------------------------------------------------------
  assign evtSet[`EVT_LOST] = |(hwSet & pendR);
  assign evtSet[`EVT_ACK]  = ackNow;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      evtStatR <= '0;
    end else begin
      evtStatR <= (wrStb && address == `IDX_EVT_CLR) ?
                  ((evtStatR & ~wByte[`EVT_WIDTH-1:0]) | evtSet) : (evtStatR | evtSet);
    end
  end

  assign irq = |(evtStatR & evtEnR);

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  logic higherWaiting;
  always_comb begin
    higherWaiting = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (arb.pend[i] && arb.levels[2*i +: 2] > arb.level) begin
        higherWaiting = 1'b1;
      end
    end
  end

  sequence s_stall;
    waitrequest && !respondR;
  endsequence
  sequence s_done;
    !waitrequest && respondR;
  endsequence

  property p_bus_one_wait;
    ((read || write) && !respondR) |-> s_stall ##1 s_done;
  endproperty
  a_bus_one_wait: assert property (p_bus_one_wait)
    else $error("bus access did not finish after one wait state");

  property p_hw_sets;
    (hwSet != '0) |=> ((pendR & $past(hwSet)) == $past(hwSet));
  endproperty
  a_hw_sets: assert property (p_hw_sets)
    else $error("hardware request did not set its flag");

  property p_ack_clears;
    (ackMask != '0 && (ackMask & hwSet) == '0) |=> ((pendR & $past(ackMask)) == '0);
  endproperty
  a_ack_clears: assert property (p_ack_clears)
    else $error("acknowledged flag was not cleared");

  property p_forward_gated;
    coreIrqReq |-> $past(masterEnR) && coreIrqLevel != LVL_OFF;
  endproperty
  a_forward_gated: assert property (p_forward_gated)
    else $error("request forwarded while disabled or at level off");

  property p_disabled_quiet;
    !masterEnR [*2] |-> !coreIrqReq;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("request forwarded with master enable low");

  property p_forward_pending;
    (masterEnR && arb.found) |=> coreIrqReq && coreIrqVector == $past(arb.winner);
  endproperty
  a_forward_pending: assert property (p_forward_pending)
    else $error("enabled pending request not forwarded");

  property p_highest_first;
    arb.found |-> !higherWaiting;
  endproperty
  a_highest_first: assert property (p_highest_first)
    else $error("a higher level request was passed over");

  property p_lo_reserved;
    (read && !respondR && address == `IDX_G0_LO) |=> (readdata[7:0] & ~`G0_IMPL_MASK) == 8'h00;
  endproperty
  a_lo_reserved: assert property (p_lo_reserved)
    else $error("reserved low enable bits read non-zero");

  property p_sw_raise;
    (wrStb && address == `IDX_PA_REQ) |=> ((pendR[`PA_BASE +: 8] & $past(wByte)) == $past(wByte));
  endproperty
  a_sw_raise: assert property (p_sw_raise)
    else $error("software write of one did not raise the flag");

  property p_level_decode;
    (arb.found && arb.winner < src_idx_t'(8))
      |-> arb.level == prio_level_t'({g0HiR[arb.winner[2:0]], g0LoR[arb.winner[2:0]]});
  endproperty
  a_level_decode: assert property (p_level_decode)
    else $error("group 0 level does not match its enable pair");

endmodule // irq_request_priority_enable

/* File: dv/core_ack_model.sv */
// Behavioural processor core that takes vectored requests and acknowledges them.
// Assumes the block holds its request, vector and level until acknowledged.
`timescale 1ns/100ps
module core_ack_model (
  // Clock and reset
  input  wire logic                       clock,
  input  wire logic                       reset_n,
  // Control from the bench
  input  wire logic                       ackOn,
  input  wire logic [3:0]                 ackDelay,
  // Request from the block
  input  wire logic                       coreIrqReq,
  input  wire irq_prio_pkg::src_idx_t     coreIrqVector,
  input  wire irq_prio_pkg::prio_level_t  coreIrqLevel,
  output logic                            coreIrqAck,
  // Record of the requests taken
  output irq_prio_pkg::src_idx_t          takenVector,
  output irq_prio_pkg::prio_level_t       takenLevel,
  output logic [7:0]                      takenCount
);
  import irq_prio_pkg::*;

  logic [3:0] waitCnt_r;

  // ---------------------------------------------------------------------------
  // Acknowledge
  // ---------------------------------------------------------------------------
  // Never two pulses in a row: the block needs one cycle to show its next winner
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      coreIrqAck  <= 1'b0;
      waitCnt_r   <= 4'h0;
      takenVector <= '0;
      takenLevel  <= LVL_OFF;
      takenCount  <= 8'h00;
    end else begin
      coreIrqAck <= 1'b0;
      if (ackOn && coreIrqReq && !coreIrqAck) begin
        if (waitCnt_r >= ackDelay) begin
          coreIrqAck  <= 1'b1;
          waitCnt_r   <= 4'h0;
          takenVector <= coreIrqVector;
          takenLevel  <= coreIrqLevel;
          takenCount  <= takenCount + 8'h01;
        end else begin
          waitCnt_r <= waitCnt_r + 4'h1;
        end
      end else begin
        waitCnt_r <= 4'h0;
      end
    end
  end
endmodule // core_ack_model

/* File: dv/testbench.sv */
// Self-checking bench of the interrupt request and priority block.
// Assumes the core model sits on the vectored request port.
`timescale 1ns/100ps
`include "irq_prio_defines.svh"
module testbench;
  import irq_prio_pkg::*;

  logic        clock, reset_n, read, write, waitrequest, irq;
  logic [11:0] address;
  logic [31:0] writedata, readdata;
  logic [7:0]  evtBits, portAPin, takenCount;
  logic [3:0]  portCPin, ackDelay;
  logic        lowVoltageLevel, comparatorLevel, ackOn, coreIrqReq, coreIrqAck;
  src_idx_t    coreIrqVector, takenVector;
  prio_level_t coreIrqLevel, takenLevel;
  int          err_count, checks_done, expCount;
  logic [7:0]  rd;

  irq_request_priority_enable DUT (.clock(clock), .reset_n(reset_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .timer1Event(evtBits[6]), .timer0Event(evtBits[5]), .serialRxEvent(evtBits[4]),
    .serialTxEvent(evtBits[3]), .converterEvent(evtBits[0]), .lowVoltageLevel(lowVoltageLevel),
    .comparatorLevel(comparatorLevel), .portAPin(portAPin), .portCPin(portCPin),
    .coreIrqReq(coreIrqReq), .coreIrqVector(coreIrqVector), .coreIrqLevel(coreIrqLevel),
    .coreIrqAck(coreIrqAck), .irq(irq));

  core_ack_model core (.clock(clock), .reset_n(reset_n), .ackOn(ackOn), .ackDelay(ackDelay),
    .coreIrqReq(coreIrqReq), .coreIrqVector(coreIrqVector), .coreIrqLevel(coreIrqLevel),
    .coreIrqAck(coreIrqAck), .takenVector(takenVector), .takenLevel(takenLevel),
    .takenCount(takenCount));

  // ---------------------------------------------------------------------------
  // Report and compare
  // ---------------------------------------------------------------------------
  task complete_run;
    if (err_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task check_v(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask

  task check_b(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask

  // ---------------------------------------------------------------------------
  // Bus, stimulus and waits
  // ---------------------------------------------------------------------------
  // Every access starts after a rising edge, so back-to-back calls leave one idle edge
  task bus_xfer(input logic wr, input logic [11:0] a, input logic [7:0] d, output logic [7:0] q);
    int   n;
    logic w;
    @(posedge clock);
    address   <= a;
    writedata <= {24'h0, d};
    write     <= wr;
    read      <= !wr;
    n = 0;
    do begin
      @(negedge clock);
      w = waitrequest;
      q = readdata[7:0];
      @(posedge clock);
      n++;
    end while (w !== 1'b0 && n < 20);
    write <= 1'b0;
    read  <= 1'b0;
    if (n >= 20) begin
      err_count++;
      complete_run();
    end
  endtask

  task bus_write(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus_xfer(1'b1, a, d, q);
  endtask

  task read_check(input logic [11:0] a, input logic [7:0] exp);
    bus_xfer(1'b0, a, 8'h00, rd);
    check_v(rd, exp);
  endtask

  task pulse(input logic [7:0] m);
    @(posedge clock);
    evtBits <= m;
    @(posedge clock);
    evtBits <= 8'h00;
    repeat (3) @(posedge clock);
  endtask

  task settle(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask

  task wait_taken;
    int n;
    expCount++;
    n = 0;
    while (takenCount !== expCount[7:0] && n < 200) begin
      @(posedge clock);
      n++;
    end
    if (n >= 200) begin
      err_count++;
      complete_run();
    end
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task t_reset;
    logic [11:0] idx [11] = '{12'hfc0, 12'hfc1, 12'hfc2, 12'hfc3, 12'hfc4, 12'hfc5, 12'hfc6,
                              12'hfce, 12'hfcf, 12'hfd0, 12'hfd2};
    foreach (idx[i]) read_check(idx[i], `REG_RESET);
    check_b(coreIrqReq, 1'b0);
    check_b(irq, 1'b0);
  endtask

  task t_reserved;
    logic [11:0] idx [6] = '{`IDX_G0_HI, `IDX_G0_LO, `IDX_SHARED, `IDX_CTRL, `IDX_PC_REQ, 12'hfc8};
    // Reserved group 0 enable bits are written as zero, as software must
    logic [7:0]  wv  [6] = '{8'h79, 8'h79, 8'hff, 8'hff, 8'h0f, 8'hff};
    logic [7:0]  ev  [6] = '{8'h79, 8'h79, 8'hc0, 8'h80, 8'h0f, 8'h00};
    foreach (idx[i]) begin
      bus_write(idx[i], wv[i]);
      read_check(idx[i], ev[i]);
    end
    foreach (idx[i]) bus_write(idx[i], 8'h00);
    read_check(`IDX_PC_REQ, 8'h00);
  endtask

  task t_mapping;
    logic [7:0] m;
    m = `G0_IMPL_MASK;
    for (int i = 0; i < 8; i++) begin
      if (m[i]) begin
        pulse(8'h01 << i);
        read_check(`IDX_G0_REQ, 8'h01 << i);
        bus_write(`IDX_G0_REQ, 8'h00);
      end
    end
  endtask

  task t_levels;
    logic [1:0] c;
    for (int k = 0; k < 4; k++) begin
      c = k[1:0];
      bus_write(`IDX_G0_HI, {1'b0, c[1], 6'h00});
      bus_write(`IDX_G0_LO, {1'b0, c[0], 6'h00});
      pulse(8'h40);
      settle(1);
      check_b(coreIrqReq, 1'b0);
      read_check(`IDX_G0_REQ, 8'h40);
      bus_write(`IDX_CTRL, 8'h80);
      settle(2);
      check_b(coreIrqReq, c != 2'h0);
      if (c != 2'h0) begin
        check_v({3'h0, coreIrqVector}, 8'h06);
        check_v({6'h0, coreIrqLevel}, {6'h0, c});
        @(posedge clock);
        ackOn <= 1'b1;
        wait_taken();
        ackOn <= 1'b0;
      end else begin
        bus_write(`IDX_G0_REQ, 8'h00);
      end
      read_check(`IDX_G0_REQ, 8'h00);
      bus_write(`IDX_CTRL, 8'h00);
    end
    check_b(irq, 1'b0);
  endtask

  task t_order;
    src_idx_t    vec [3] = '{5'd10, 5'd13, 5'd6};
    prio_level_t lvl [3] = '{LVL_HIGH, LVL_HIGH, LVL_MED};
    bus_write(`IDX_EVT_EN, 8'h02);
    settle(1);
    check_b(irq, 1'b1);
    bus_write(`IDX_EVT_CLR, 8'h02);
    settle(1);
    check_b(irq, 1'b0);
    bus_write(`IDX_PA_HI, 8'h24);
    bus_write(`IDX_PA_LO, 8'h24);
    bus_write(`IDX_G0_HI, 8'h40);
    bus_write(`IDX_G0_LO, 8'h00);
    pulse(8'h40);
    bus_write(`IDX_PA_REQ, 8'h24);
    @(posedge clock);
    ackDelay <= 4'h3;
    ackOn    <= 1'b1;
    bus_write(`IDX_CTRL, 8'h80);
    foreach (vec[i]) begin
      wait_taken();
      check_v({3'h0, takenVector}, {3'h0, vec[i]});
      check_v({6'h0, takenLevel}, {6'h0, lvl[i]});
    end
    ackOn <= 1'b0;
    settle(2);
    check_b(irq, 1'b1);
    read_check(`IDX_EVT_STAT, 8'h02);
    // A second converter request on a set flag marks a lost request
    pulse(8'h01);
    pulse(8'h01);
    read_check(`IDX_EVT_STAT, 8'h03);
    read_check(`IDX_G0_REQ, 8'h01);
    bus_write(`IDX_EVT_CLR, 8'h03);
    bus_write(`IDX_G0_REQ, 8'h00);
    bus_write(`IDX_CTRL, 8'h00);
    settle(1);
    check_b(irq, 1'b0);
  endtask

  task t_shared;
    bus_write(`IDX_SHARED, 8'hc0);
    portAPin <= 8'hc0;
    settle(8);
    read_check(`IDX_PA_REQ, 8'h00);
    @(posedge clock);
    lowVoltageLevel <= 1'b1;
    comparatorLevel <= 1'b1;
    settle(3);
    read_check(`IDX_PA_REQ, 8'hc0);
    @(posedge clock);
    portAPin        <= 8'h00;
    lowVoltageLevel <= 1'b0;
    comparatorLevel <= 1'b0;
    settle(8);
    bus_write(`IDX_SHARED, 8'h00);
    bus_write(`IDX_PA_REQ, 8'h00);
    portAPin <= 8'h43;
    portCPin <= 4'h5;
    settle(10);
    read_check(`IDX_PA_REQ, 8'h43);
    read_check(`IDX_PC_REQ, 8'h05);
  endtask

  // ---------------------------------------------------------------------------
  // Clock, reset and main sequence
  // ---------------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial begin
    reset_n = 1'b0;
    {read, write, lowVoltageLevel, comparatorLevel, ackOn} = '0;
    address   = 12'h000;
    writedata = 32'h0;
    evtBits   = 8'h00;
    portAPin  = 8'h00;
    portCPin  = 4'h0;
    ackDelay  = 4'h0;
    err_count = 0;
    checks_done = 0;
    expCount  = 0;
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    t_reset();
    t_reserved();
    t_mapping();
    t_levels();
    t_order();
    t_shared();
    complete_run();
  end
endmodule // testbench
